// >>> shared/nia_pkg.sv
// Constants and carrier types for the NMI and interrupt aggregator
package nia_pkg;

  // CPU I/O addresses
  localparam logic [15:0] ADDR_NMI_MASK   = 16'h00A0;
  localparam logic [11:0] ADDR_PIC_BLOCK  = 12'h002;
  localparam logic [13:0] ADDR_NMI_VEC    = 14'h2103;
  localparam logic [15:0] ADDR_SUM_STAT   = 16'h8410;
  localparam logic [15:0] ADDR_SUM_EN     = 16'h8411;
  localparam logic [15:0] ADDR_PWR_STAT   = 16'h8412;
  localparam logic [15:0] ADDR_PWR_EN     = 16'h8413;
  localparam logic [15:0] ADDR_PWR_SRC    = 16'h8414;
  localparam logic [15:0] ADDR_TRAP_TOP   = 16'h8422;
  localparam logic [15:0] ADDR_VIOL_TOP   = 16'h8426;
  localparam logic [15:0] ADDR_ACT_MASK   = 16'h842B;
  localparam logic [15:0] ADDR_SCAN_CODE  = 16'h8430;
  localparam logic [15:0] ADDR_TICK_IRQ   = 16'h8444;
  localparam logic [15:0] ADDR_TIMER_IRQ  = 16'h8448;
  localparam logic [15:0] ADDR_RTC_IRQ    = 16'h8458;

  // Memory vector fetch window, word address of 0C008-0C00B
  localparam logic [17:0] VEC_FETCH_WORD  = 18'h0_3002;

  // Field positions
  localparam int NMI_EN_BIT      = 7;
  localparam int SUM_VIOL_BIT    = 0;
  localparam int SUM_CARD_BIT    = 1;
  localparam int SUM_SERV_BIT    = 2;
  localparam int SUM_PWR_BIT     = 3;
  localparam int SUM_KEY_BIT     = 4;
  localparam int SUM_WAKE_BIT    = 5;
  localparam int PIC_ICW1_BIT    = 4;
  localparam int PIC_OCW3_BIT    = 3;
  localparam int PIC_LTIM_BIT    = 3;
  localparam int PIC_SNGL_BIT    = 1;
  localparam int PIC_IC4_BIT     = 0;
  localparam int PIC_AEOI_BIT    = 1;

  // Values after reset, and the summary enable write mask
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_PIC_MASK = 8'hFF;
  localparam logic [7:0] SUM_RD_MASK  = 8'h3F;

  // PIC command codes (OCW2 top bits)
  localparam logic [2:0] OCW2_NS_EOI   = 3'b001;
  localparam logic [2:0] OCW2_SP_EOI   = 3'b011;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int PSRC_PERIOD_NS = 1_000_000;
  localparam int PSRC_CYCLES = PSRC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_W = 23;

  typedef struct packed {
    logic main_cells_low;
    logic main_cells_flat;
    logic backup_cell_flat;
    logic expansion_cells_low;
    logic expansion_cells_flat;
    logic card_a_battery_low;
    logic card_b_battery_low;
    logic external_power_low;
  } nia_pwr_t;

  typedef struct packed {
    logic scan_code_read;
    logic rtc_irq_read;
    logic tick_irq_read;
    logic timer_irq_read;
    logic violation_top_read;
    logic trap_top_read;
    logic activity_mask_read;
  } nia_clr_t;

  typedef enum logic [1:0] {
    PIC_READY,
    PIC_WAIT_ICW2,
    PIC_WAIT_ICW3,
    PIC_WAIT_ICW4
  } nia_pic_st_t;

endpackage

// >>> design/nia_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module nia_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] d_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= '0;
      d_sync <= '0;
    end else begin
      meta_r <= d_async;
      d_sync <= meta_r;
    end
  end

endmodule

// >>> design/nia_top.sv
// NMI aggregation, status registers and eight-level vectored controller
//
// Function
// - Write-only mask at 0A0h, D7 enables
// - System NMI disabled after every reset
// - Mask register accesses repeated on expansion bus
// - Port B bit5 gates check; write clears
// - Specific NMI vector fetch gets substituted bytes
// - I/O-check-only NMI reads ordinary memory
// - Summary status bits per pending source
// - Summary read clears D1,D4,D5; D7:D6 zero
// - Summary enable register gates each source
// - Power status bits per power condition
// - Power status read clears all bits
// - Power enable register gates each source
// - Power source state refreshed every millisecond
// - Eight levels: timer, keyboard, expansion bus
// - Controller decoded at 020-02Fh, A0 conventional
// - Buffer-enable held high: unbuffered master
// - Sources cleared by their documented reads
// - Two NMI classes merged onto processor
`timescale 1ns/1ps
module nia_top #(
  parameter int PSRC_CYC = nia_pkg::PSRC_CYCLES
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // CPU I/O port
  input  wire logic [15:0]      io_addr,
  input  wire logic [7:0]       io_wdata,
  input  wire logic             io_rd,
  input  wire logic             io_wr,
  output logic      [7:0]       io_rdata,
  output logic                  io_rvalid,
  // Expansion bus echo
  output logic                  exp_io_rd,
  output logic                  exp_io_wr,
  output logic      [7:0]       exp_io_data,
  // Memory vector fetch
  input  wire logic [19:0]      mem_addr,
  input  wire logic             mem_rd,
  output logic                  vec_hit,
  output logic      [7:0]       vec_data,
  // NMI sources
  input  wire logic             bus_io_check,
  input  wire logic             port_b_bit5,
  input  wire logic             port_b_write,
  input  wire logic             key_action_irq,
  input  wire logic             key_wakeup_irq,
  input  wire logic             internal_service_irq,
  input  wire logic             memory_card_irq,
  input  wire logic             access_violation_irq,
  input  wire nia_pkg::nia_pwr_t power_irq_raw,
  input  wire nia_pkg::nia_pwr_t power_source_raw,
  output nia_pkg::nia_clr_t     src_clear,
  output logic                  nmi,
  // Vectored controller
  input  wire logic             timer_out0,
  input  wire logic             kbd_rx_irq,
  input  wire logic [7:2]       exp_irq,
  input  wire logic             inta,
  output logic                  pic_int,
  output logic      [7:0]       pic_vector,
  output logic                  pic_vector_valid,
  output logic                  slave_program_buffer_enable
);

  // Lowest set index wins; bit 3 flags that any bit was set
  function automatic logic [3:0] prio_idx(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic rd_at(input logic [15:0] a);
    return io_rd && io_addr == a;
  endfunction

  // Pin inputs
  logic [nia_pkg::SYNC_W-1:0] sync_q;
  logic                       bus_io_check_s;
  logic [7:2]                 exp_irq_s;
  nia_pkg::nia_pwr_t          pwr_irq_s;
  nia_pkg::nia_pwr_t          pwr_src_s;

  nia_sync #(
    .W (nia_pkg::SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d_async ({bus_io_check, exp_irq, power_irq_raw, power_source_raw}),
    .d_sync  (sync_q)
  );

  assign {bus_io_check_s, exp_irq_s, pwr_irq_s, pwr_src_s} = sync_q;

  // Address decode
  logic rd_sum, rd_pwr, wr_mask, sel_pic, sel_vec;
  assign rd_sum  = io_rd && io_addr == nia_pkg::ADDR_SUM_STAT;
  assign rd_pwr  = io_rd && io_addr == nia_pkg::ADDR_PWR_STAT;
  assign wr_mask = io_wr && io_addr == nia_pkg::ADDR_NMI_MASK;
  assign sel_pic = io_addr[15:4] == nia_pkg::ADDR_PIC_BLOCK;
  assign sel_vec = io_addr[15:2] == nia_pkg::ADDR_NMI_VEC;

  // Software registers
  logic       nmi_en_r;
  logic [7:0] sum_en_r, pwr_en_r;
  logic [7:0] vec_r [4];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi_en_r <= 1'b0;
    end else if (wr_mask) begin
      nmi_en_r <= io_wdata[nia_pkg::NMI_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sum_en_r <= nia_pkg::RST_BYTE;
      pwr_en_r <= nia_pkg::RST_BYTE;
    end else if (io_wr) begin
      if (io_addr == nia_pkg::ADDR_SUM_EN) begin
        sum_en_r <= io_wdata & nia_pkg::SUM_RD_MASK;
      end
      if (io_addr == nia_pkg::ADDR_PWR_EN) begin
        pwr_en_r <= io_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        vec_r[i] <= nia_pkg::RST_BYTE;
      end
    end else if (io_wr && sel_vec) begin
      vec_r[io_addr[1:0]] <= io_wdata;
    end
  end

  // Mask accesses are also seen on the expansion bus
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      exp_io_rd   <= 1'b0;
      exp_io_wr   <= 1'b0;
      exp_io_data <= nia_pkg::RST_BYTE;
    end else begin
      exp_io_rd <= rd_at(nia_pkg::ADDR_NMI_MASK);
      exp_io_wr <= wr_mask;
      if (wr_mask) begin
        exp_io_data <= io_wdata;
      end
    end
  end

  // I/O check pending; a new check beats a clearing port B write
  logic bus_io_check_pend_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_io_check_pend_r <= 1'b0;
    end else if (bus_io_check_s && !port_b_bit5) begin
      bus_io_check_pend_r <= 1'b1;
    end else if (port_b_write) begin
      bus_io_check_pend_r <= 1'b0;
    end
  end

  // Power status: sticky on rising condition, cleared by read
  nia_pkg::nia_pwr_t pwr_prev_r;
  logic [7:0]        pwr_stat_r, pwr_src_r;
  logic [7:0]        pwr_rise;
  assign pwr_rise = pwr_irq_s & ~pwr_prev_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwr_prev_r <= '0;
      pwr_stat_r <= nia_pkg::RST_BYTE;
    end else begin
      pwr_prev_r <= pwr_irq_s;
      pwr_stat_r <= (rd_pwr ? 8'h00 : pwr_stat_r) | pwr_rise;
    end
  end

  // Power source state sampled once per period
  logic [$clog2(PSRC_CYC)-1:0] ms_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ms_cnt_r  <= '0;
      pwr_src_r <= nia_pkg::RST_BYTE;
    end else if (ms_cnt_r == ($clog2(PSRC_CYC))'(PSRC_CYC - 1)) begin
      ms_cnt_r  <= '0;
      pwr_src_r <= pwr_src_s;
    end else begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  // Summary status; only D1, D4, D5 are held here
  logic [7:0] sum_stat;
  logic       card_r, key_r, wake_r;
  logic       power_summary_irq;
  assign power_summary_irq = |(pwr_stat_r & pwr_en_r);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      card_r <= 1'b0;
      key_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      card_r <= memory_card_irq | (card_r & ~rd_sum);
      key_r  <= key_action_irq | (key_r & ~rd_sum);
      wake_r <= key_wakeup_irq | (wake_r & ~rd_sum);
    end
  end

  always_comb begin
    sum_stat = nia_pkg::RST_BYTE;
    sum_stat[nia_pkg::SUM_VIOL_BIT] = access_violation_irq;
    sum_stat[nia_pkg::SUM_CARD_BIT] = card_r;
    sum_stat[nia_pkg::SUM_SERV_BIT] = internal_service_irq;
    sum_stat[nia_pkg::SUM_PWR_BIT]  = power_summary_irq;
    sum_stat[nia_pkg::SUM_KEY_BIT]  = key_r;
    sum_stat[nia_pkg::SUM_WAKE_BIT] = wake_r;
  end

  // Clear notices to the blocks that hold the other sources
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      src_clear <= '0;
    end else begin
      src_clear.scan_code_read <= rd_at(nia_pkg::ADDR_SCAN_CODE);
      src_clear.rtc_irq_read <= rd_at(nia_pkg::ADDR_RTC_IRQ);
      src_clear.tick_irq_read <= rd_at(nia_pkg::ADDR_TICK_IRQ);
      src_clear.timer_irq_read <= rd_at(nia_pkg::ADDR_TIMER_IRQ);
      src_clear.violation_top_read <= rd_at(nia_pkg::ADDR_VIOL_TOP);
      src_clear.trap_top_read <= rd_at(nia_pkg::ADDR_TRAP_TOP);
      src_clear.activity_mask_read <= rd_at(nia_pkg::ADDR_ACT_MASK);
    end
  end

  // NMI merge and vector substitution
  logic spec_cause, nmi_nxt, spec_ack_r, vec_win;
  assign spec_cause = |(sum_stat & sum_en_r);
  assign nmi_nxt = (bus_io_check_pend_r & nmi_en_r) | spec_cause;
  assign vec_win = mem_rd && mem_addr[19:2] == nia_pkg::VEC_FETCH_WORD;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nmi        <= 1'b0;
      spec_ack_r <= 1'b0;
    end else begin
      nmi <= nmi_nxt;
      if (nmi_nxt && !nmi && spec_cause) begin
        spec_ack_r <= 1'b1;
      end else if (vec_win && mem_addr[1:0] == 2'b11) begin
        spec_ack_r <= 1'b0;
      end
    end
  end

  // An I/O-check-only NMI leaves spec_ack_r low, so memory answers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vec_hit  <= 1'b0;
      vec_data <= nia_pkg::RST_BYTE;
    end else begin
      vec_hit <= vec_win && spec_ack_r;
      if (vec_win && spec_ack_r) begin
        vec_data <= vec_r[mem_addr[1:0]];
      end
    end
  end

  // Vectored controller
  nia_pkg::nia_pic_st_t pic_st_r;
  logic [7:0]        irr_r, isr_r, imr_r, lvl_prev_r, icw1_r, icw2_r, icw4_r;
  logic              rd_isr_r;
  logic [7:0]        lvl;
  logic [3:0]        req_p, srv_p;
  logic              pic_wr_even, pic_wr_odd;
  assign lvl = {exp_irq_s, kbd_rx_irq, timer_out0};
  assign req_p = prio_idx(irr_r & ~imr_r);
  assign srv_p = prio_idx(isr_r);
  assign pic_wr_even = io_wr && sel_pic && !io_addr[0];
  assign pic_wr_odd  = io_wr && sel_pic && io_addr[0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pic_st_r <= nia_pkg::PIC_READY;
      icw1_r   <= nia_pkg::RST_BYTE;
      icw2_r   <= nia_pkg::RST_BYTE;
      icw4_r   <= nia_pkg::RST_BYTE;
      imr_r    <= nia_pkg::RST_PIC_MASK;
      rd_isr_r <= 1'b0;
    end else if (pic_wr_even && io_wdata[nia_pkg::PIC_ICW1_BIT]) begin
      icw1_r   <= io_wdata;
      imr_r    <= nia_pkg::RST_BYTE;
      icw4_r   <= nia_pkg::RST_BYTE;
      pic_st_r <= nia_pkg::PIC_WAIT_ICW2;
    end else if (pic_wr_even && io_wdata[nia_pkg::PIC_OCW3_BIT]) begin
      if (io_wdata[1]) begin
        rd_isr_r <= io_wdata[0];
      end
    end else if (pic_wr_odd) begin
      unique case (pic_st_r)
        nia_pkg::PIC_WAIT_ICW2: begin
          icw2_r <= io_wdata;
          if (!icw1_r[nia_pkg::PIC_SNGL_BIT]) begin
            pic_st_r <= nia_pkg::PIC_WAIT_ICW3;
          end else if (icw1_r[nia_pkg::PIC_IC4_BIT]) begin
            pic_st_r <= nia_pkg::PIC_WAIT_ICW4;
          end else begin
            pic_st_r <= nia_pkg::PIC_READY;
          end
        end
        nia_pkg::PIC_WAIT_ICW3: begin
          pic_st_r <= icw1_r[nia_pkg::PIC_IC4_BIT] ? nia_pkg::PIC_WAIT_ICW4
                                                   : nia_pkg::PIC_READY;
        end
        nia_pkg::PIC_WAIT_ICW4: begin
          icw4_r   <= io_wdata;
          pic_st_r <= nia_pkg::PIC_READY;
        end
        nia_pkg::PIC_READY: begin
          imr_r <= io_wdata;
        end
      endcase
    end
  end

  // Requests; edge mode latches rising inputs, level mode follows them
  logic ack_now;
  assign ack_now = inta && req_p[3];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lvl_prev_r <= nia_pkg::RST_BYTE;
      irr_r      <= nia_pkg::RST_BYTE;
    end else begin
      lvl_prev_r <= lvl;
      for (int i = 0; i < 8; i++) begin
        if (icw1_r[nia_pkg::PIC_LTIM_BIT]) begin
          irr_r[i] <= lvl[i];
        end else if (lvl[i] && !lvl_prev_r[i]) begin
          irr_r[i] <= 1'b1;
        end else if (ack_now && req_p[2:0] == 3'(i)) begin
          irr_r[i] <= 1'b0;
        end
      end
    end
  end

  // In service: set on acknowledge unless auto end, cleared by EOI
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      isr_r <= nia_pkg::RST_BYTE;
    end else if (pic_wr_even && io_wdata[4:3] == 2'b00) begin
      if (io_wdata[7:5] == nia_pkg::OCW2_NS_EOI && srv_p[3]) begin
        isr_r[srv_p[2:0]] <= 1'b0;
      end else if (io_wdata[7:5] == nia_pkg::OCW2_SP_EOI) begin
        isr_r[io_wdata[2:0]] <= 1'b0;
      end
    end else if (ack_now && !icw4_r[nia_pkg::PIC_AEOI_BIT]) begin
      isr_r[req_p[2:0]] <= 1'b1;
    end
  end

  // Fully nested: only a higher level interrupts one in service
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pic_int          <= 1'b0;
      pic_vector       <= nia_pkg::RST_BYTE;
      pic_vector_valid <= 1'b0;
      slave_program_buffer_enable <= 1'b0;
    end else begin
      slave_program_buffer_enable <= 1'b1;
      pic_int <= req_p[3] && (!srv_p[3] || req_p[2:0] < srv_p[2:0])
                 && !ack_now;
      pic_vector_valid <= inta;
      if (inta) begin
        pic_vector <= {icw2_r[7:3], req_p[2:0]};
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata  <= nia_pkg::RST_BYTE;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_rd;
      if (io_rd) begin
        if (rd_sum) begin
          io_rdata <= sum_stat;
        end else if (rd_pwr) begin
          io_rdata <= pwr_stat_r;
        end else if (io_addr == nia_pkg::ADDR_SUM_EN) begin
          io_rdata <= sum_en_r;
        end else if (io_addr == nia_pkg::ADDR_PWR_EN) begin
          io_rdata <= pwr_en_r;
        end else if (io_addr == nia_pkg::ADDR_PWR_SRC) begin
          io_rdata <= pwr_src_r;
        end else if (sel_vec) begin
          io_rdata <= vec_r[io_addr[1:0]];
        end else if (sel_pic) begin
          io_rdata <= io_addr[0] ? imr_r : (rd_isr_r ? isr_r : irr_r);
        end else begin
          io_rdata <= nia_pkg::RST_BYTE;
        end
      end
    end
  end

endmodule

// >>> sim/nia_monitor.sv
// Port-level concurrent checks for the NMI and interrupt aggregator
`timescale 1ns/1ps
module nia_monitor (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  // CPU I/O port and expansion echo
  input wire logic [15:0]       io_addr,
  input wire logic [7:0]        io_wdata,
  input wire logic              io_rd,
  input wire logic              io_wr,
  input wire logic [7:0]        io_rdata,
  input wire logic              exp_io_rd,
  input wire logic              exp_io_wr,
  input wire logic [7:0]        exp_io_data,
  // Vector fetch, controller, source clears
  input wire logic [19:0]       mem_addr,
  input wire logic              mem_rd,
  input wire logic              vec_hit,
  input wire logic              inta,
  input wire logic              pic_vector_valid,
  input wire logic              slave_program_buffer_enable,
  input wire nia_pkg::nia_clr_t src_clear
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_rd_at(logic [15:0] a);
    io_rd && io_addr == a;
  endsequence
  // Vector valid is a single-cycle pulse
  sequence s_vec_once;
    pic_vector_valid ##1 !pic_vector_valid;
  endsequence

  property p_mask_rd_zero;
    s_rd_at(nia_pkg::ADDR_NMI_MASK) |=> io_rdata == 8'h00;
  endproperty
  a_mask_rd_zero: assert property (p_mask_rd_zero)
    else $error("mask register read back nonzero");

  property p_echo_wr;
    io_wr && io_addr == nia_pkg::ADDR_NMI_MASK
      |=> exp_io_wr && exp_io_data == $past(io_wdata);
  endproperty
  a_echo_wr: assert property (p_echo_wr)
    else $error("mask write not echoed with its data");

  property p_echo_rd;
    s_rd_at(nia_pkg::ADDR_NMI_MASK) |=> exp_io_rd;
  endproperty
  a_echo_rd: assert property (p_echo_rd)
    else $error("mask read not echoed");

  property p_echo_only;
    exp_io_wr || exp_io_rd |-> $past(io_addr) == nia_pkg::ADDR_NMI_MASK
      && ($past(io_wr) || $past(io_rd));
  endproperty
  a_echo_only: assert property (p_echo_only)
    else $error("echo without a mask register access");

  property p_sum_top;
    s_rd_at(nia_pkg::ADDR_SUM_STAT) |=> io_rdata[7:6] == 2'b00;
  endproperty
  a_sum_top: assert property (p_sum_top)
    else $error("summary status top bits nonzero");

  property p_vec_win;
    vec_hit |-> $past(mem_rd)
      && ($past(mem_addr) >> 2) == 20'(nia_pkg::VEC_FETCH_WORD);
  endproperty
  a_vec_win: assert property (p_vec_win)
    else $error("vector hit outside fetch window");

  property p_spbe;
    $past(sys_rst) == 1'b0 |-> slave_program_buffer_enable;
  endproperty
  a_spbe: assert property (p_spbe)
    else $error("buffer enable low after reset");

  property p_scan_clr;
    s_rd_at(nia_pkg::ADDR_SCAN_CODE) |=> src_clear.scan_code_read;
  endproperty
  a_scan_clr: assert property (p_scan_clr)
    else $error("scan code read gave no clear");

  property p_rtc_only;
    src_clear.rtc_irq_read |-> $past(io_rd)
      && $past(io_addr) == nia_pkg::ADDR_RTC_IRQ;
  endproperty
  a_rtc_only: assert property (p_rtc_only)
    else $error("clock clear without its read");

  property p_ack_vec;
    inta |=> s_vec_once;
  endproperty
  a_ack_vec: assert property (p_ack_vec)
    else $error("acknowledge gave no single vector pulse");
endmodule

bind nia_top nia_monitor u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata),
  .exp_io_rd(exp_io_rd), .exp_io_wr(exp_io_wr), .exp_io_data(exp_io_data),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .vec_hit(vec_hit), .inta(inta),
  .pic_vector_valid(pic_vector_valid), .src_clear(src_clear),
  .slave_program_buffer_enable(slave_program_buffer_enable)
);

// >>> sim/nia_host_model.sv
// Behavioural host processor: interrupt acknowledge and NMI vector fetch
`timescale 1ns/1ps
module nia_host_model (
  // Clock
  input wire logic        clk_sys,
  // Vectored controller
  input wire logic        pic_int,
  input wire logic [7:0]  pic_vector,
  input wire logic        pic_vector_valid,
  output logic            inta,
  // NMI vector fetch
  input wire logic        vec_hit,
  input wire logic [7:0]  vec_data,
  output logic            mem_rd,
  output logic [19:0]     mem_addr
);
  initial begin
    inta = 1'b0;
    mem_rd = 1'b0;
    mem_addr = 20'hF_FFFF;
  end

  // One acknowledge pulse per request; q_ok stays low if none came
  task automatic do_ack(output logic [7:0] q, output logic q_ok);
    int n;
    n = 0;
    while (pic_int !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    inta = 1'b1;
    @(negedge clk_sys);
    inta = 1'b0;
    q = pic_vector;
    q_ok = pic_vector_valid && (n < 40);
  endtask

  // Idle address is inverted so a stale value never looks selected
  task automatic do_fetch(output logic [31:0] q, output logic [3:0] hit);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      mem_addr = 20'h0_C008 + 20'(i);
      mem_rd = 1'b1;
      @(negedge clk_sys);
      mem_rd = 1'b0;
      mem_addr = ~mem_addr;
      q[8*i +: 8] = vec_data;
      hit[i] = vec_hit;
    end
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the NMI and interrupt aggregator
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
  localparam int PSRC = 8;
  localparam logic [15:0] A_SUM = nia_pkg::ADDR_SUM_STAT,
    A_PWR = nia_pkg::ADDR_PWR_STAT;
  logic              clk_sys, sys_rst, io_rd, io_wr, io_rvalid, vec_hit;
  logic [15:0]       io_addr;
  logic [7:0]        io_wdata, io_rdata, vec_data, pic_vector, d, v;
  logic              mem_rd, bus_io_check, port_b_bit5, port_b_write;
  logic              nmi, inta, pic_int, pic_vector_valid, spbe, ok;
  logic [19:0]       mem_addr;
  logic [5:0]        sum_src;
  logic [7:0]        lvl;
  logic [31:0]       vb;
  logic [3:0]        hits;
  nia_pkg::nia_pwr_t pwr_irq, pwr_src;
  nia_pkg::nia_clr_t src_clear, clr;
  int                n_fail, cmp_count, cyc;
  int                sb[4] = '{0, 1, 2, 5};
  logic [15:0]       clr_a[7] = '{nia_pkg::ADDR_SCAN_CODE,
    nia_pkg::ADDR_RTC_IRQ, nia_pkg::ADDR_TICK_IRQ, nia_pkg::ADDR_TIMER_IRQ,
    nia_pkg::ADDR_VIOL_TOP, nia_pkg::ADDR_TRAP_TOP, nia_pkg::ADDR_ACT_MASK};

  nia_top #(.PSRC_CYC(PSRC)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rd(io_rd), .io_wr(io_wr), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .exp_io_rd(), .exp_io_wr(), .exp_io_data(),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .vec_hit(vec_hit),
    .vec_data(vec_data), .bus_io_check(bus_io_check),
    .port_b_bit5(port_b_bit5), .port_b_write(port_b_write),
    .key_action_irq(sum_src[4]), .key_wakeup_irq(sum_src[5]),
    .internal_service_irq(sum_src[2]), .memory_card_irq(sum_src[1]),
    .access_violation_irq(sum_src[0]), .power_irq_raw(pwr_irq),
    .power_source_raw(pwr_src), .src_clear(src_clear), .nmi(nmi),
    .timer_out0(lvl[0]), .kbd_rx_irq(lvl[1]), .exp_irq(lvl[7:2]),
    .inta(inta), .pic_int(pic_int), .pic_vector(pic_vector),
    .pic_vector_valid(pic_vector_valid),
    .slave_program_buffer_enable(spbe));

  nia_host_model host (
    .clk_sys(clk_sys), .pic_int(pic_int), .pic_vector(pic_vector),
    .pic_vector_valid(pic_vector_valid), .inta(inta), .vec_hit(vec_hit),
    .vec_data(vec_data), .mem_rd(mem_rd), .mem_addr(mem_addr));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task stop_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Run is about 500 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end

  task settle;
    repeat (6) @(negedge clk_sys);
  endtask

  task io_wr_t(input logic [15:0] a, input logic [7:0] w);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = w;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~w;
  endtask

  task io_rd_t(input logic [15:0] a, output logic [7:0] q);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    io_addr = ~a;
    q = io_rdata;
    clr = src_clear;
    `CHK(io_rvalid, 1'b1)
  endtask

  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    io_rd_t(a, d);
    `CHK(d, e)
  endtask

  initial begin
    {io_rd, io_wr, mem_rd, bus_io_check, port_b_bit5, port_b_write} = '0;
    {io_addr, io_wdata, sum_src, lvl, pwr_irq, pwr_src} = '0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    sys_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    settle;
    `CHK(spbe, 1'b1)
    `CHK(nmi, 1'b0)
    rd_chk(A_SUM, 8'h00);
    rd_chk(A_PWR, 8'h00);
    rd_chk(16'h8499, 8'h00);
    bus_io_check = 1'b1;
    settle;
    `CHK(nmi, 1'b0)
    io_wr_t(nia_pkg::ADDR_NMI_MASK, 8'h7F);
    settle;
    `CHK(nmi, 1'b0)
    rd_chk(nia_pkg::ADDR_NMI_MASK, 8'h00);
    io_wr_t(nia_pkg::ADDR_NMI_MASK, 8'h80);
    settle;
    `CHK(nmi, 1'b1)
    host.do_fetch(vb, hits);
    `CHK(hits, 4'h0)
    port_b_bit5 = 1'b1;
    io_wr_t(16'h0061, 8'h00);
    port_b_write = 1'b1;
    @(negedge clk_sys);
    port_b_write = 1'b0;
    settle;
    `CHK(nmi, 1'b0)
    bus_io_check = 1'b0;
    io_wr_t(nia_pkg::ADDR_NMI_MASK, 8'h00);
    port_b_bit5 = 1'b0;
    for (int i = 0; i < 4; i++) begin
      io_wr_t({nia_pkg::ADDR_NMI_VEC, 2'(i)}, 8'hA0 + 8'(i));
    end
    sum_src = 6'h10;
    @(negedge clk_sys);
    sum_src = 6'h00;
    settle;
    `CHK(nmi, 1'b0)
    io_wr_t(nia_pkg::ADDR_SUM_EN, 8'hFF);
    settle;
    `CHK(nmi, 1'b1)
    rd_chk(nia_pkg::ADDR_SUM_EN, 8'h3F);
    host.do_fetch(vb, hits);
    `CHK(hits, 4'hF)
    `CHK(vb, 32'hA3A2_A1A0)
    rd_chk(A_SUM, 8'h10);
    rd_chk(A_SUM, 8'h00);
    settle;
    `CHK(nmi, 1'b0)
    foreach (sb[k]) begin
      sum_src = 6'(1 << sb[k]);
      @(negedge clk_sys);
      if (sb[k] == 1 || sb[k] == 5) begin
        sum_src = 6'h00;
      end
      settle;
      `CHK(nmi, 1'b1)
      rd_chk(A_SUM, 8'(1 << sb[k]));
      rd_chk(A_SUM,
             (sb[k] == 0 || sb[k] == 2) ? 8'(1 << sb[k]) : 8'h00);
      sum_src = 6'h00;
      settle;
    end
    for (int b = 0; b < 8; b++) begin
      pwr_irq = 8'(1 << b);
      settle;
      rd_chk(A_PWR, 8'(1 << b));
      rd_chk(A_PWR, 8'h00);
      rd_chk(A_SUM, 8'h00);
      pwr_irq = 8'h00;
      settle;
    end
    io_wr_t(nia_pkg::ADDR_PWR_EN, 8'h40);
    rd_chk(nia_pkg::ADDR_PWR_EN, 8'h40);
    pwr_irq = 8'h40;
    settle;
    `CHK(nmi, 1'b1)
    rd_chk(A_SUM, 8'h08);
    rd_chk(A_PWR, 8'h40);
    rd_chk(A_SUM, 8'h00);
    pwr_src = 8'hA5;
    repeat (2 * PSRC + 6) @(negedge clk_sys);
    rd_chk(nia_pkg::ADDR_PWR_SRC, 8'hA5);
    pwr_src = 8'h5A;
    repeat (2 * PSRC + 6) @(negedge clk_sys);
    rd_chk(nia_pkg::ADDR_PWR_SRC, 8'h5A);
    foreach (clr_a[k]) begin
      io_rd_t(clr_a[k], d);
      `CHK(clr, 7'(7'h40 >> k))
    end
    io_wr_t(16'h0020, 8'h13);
    io_wr_t(16'h0021, 8'h08);
    io_wr_t(16'h0021, 8'h0D);
    io_wr_t(16'h002F, 8'h5A);
    rd_chk(16'h0021, 8'h5A);
    io_wr_t(16'h0023, 8'h00);
    rd_chk(16'h002D, 8'h00);
    for (int i = 0; i < 8; i++) begin
      lvl = 8'(1 << i);
      host.do_ack(v, ok);
      `CHK(ok, 1'b1)
      `CHK(v, 8'h08 + 8'(i))
      lvl = 8'h00;
      io_wr_t(16'h0020, 8'h20);
    end
    lvl = 8'h82;
    host.do_ack(v, ok);
    `CHK(v, 8'h09)
    io_wr_t(16'h0020, 8'h20);
    host.do_ack(v, ok);
    `CHK(v, 8'h0F)
    lvl = 8'h00;
    io_wr_t(16'h0020, 8'h20);
    settle;
    stop_test;
  end
endmodule
